// *** logic/sab_pkg.sv ***
// Package for the serial arbiter bit timer: map, fields, modes, states
package sab_pkg;
  // Register byte offsets
  localparam logic [7:0] SAB_OFF_CTRL = 8'h00;
  localparam logic [7:0] SAB_OFF_CNT = 8'h04;
  // Counter geometry
  localparam int SAB_CNT_W = 9;
  localparam int SAB_REG_W = 8;
  localparam logic [8:0] SAB_CNT_ZERO = 9'h000;
  localparam logic [8:0] SAB_CNT_ONE = 9'h001;
  localparam logic [8:0] SAB_CNT_MAX = 9'h1FF;
  // Arbitration sense points, per clock source
  localparam logic [8:0] SAB_SENSE_BUS = 9'h038;
  localparam logic [8:0] SAB_SENSE_PRE = 9'h008;
  // Bus answers
  localparam logic [1:0] SAB_RESP_OKAY = 2'h0;
  localparam logic [1:0] SAB_RESP_SLVERR = 2'h2;
  localparam logic [31:0] SAB_WORD_ZERO = 32'h00000000;
  localparam int SAB_MODE_HI_BIT = 7;
  localparam int SAB_MODE_LO_BIT = 6;
  localparam int SAB_ACLK_BIT = 4;

  typedef enum logic [1:0] {
    SAB_MODE_IDLE = 2'h0,
    SAB_MODE_MEAS = 2'h1,
    SAB_MODE_ARB = 2'h2,
    SAB_MODE_RSVD = 2'h3
  } sab_mode_t;

  typedef enum logic [3:0] {
    SAB_ST_IDLE = 4'h1,
    SAB_ST_ARM = 4'h2,
    SAB_ST_RUN = 4'h4,
    SAB_ST_STOP = 4'h8
  } sab_state_t;

  // Control and flag register layout, bit 7 down to bit 0
  typedef struct packed {
    logic mode_select_high;
    logic mode_select_low;
    logic arbitration_lost_flag;
    logic clock_select;
    logic measure_done_flag;
    logic counter_running_flag;
    logic counter_overflow_flag;
    logic counter_msb;
  } sab_ctrl_t;
endpackage

// *** logic/sab_bit_timer.sv ***
// Serial arbiter bit timer with AXI4-Lite register slave
// What this block does
// [RULE1] Done flag sets when measurement ends; control write or reset clears it, but a finish in the write's own cycle still sets it.
// [RULE2] Running flag reads one while the counter counts; reset clears it.
// [RULE3] Overflow flag sets on counter wrap; control write or reset clears it.
// [RULE4] Counter top bit readable in control register; control write or reset clears.
// [RULE5] Counter low eight bits readable in data register; cleared likewise.
// [RULE6] Mode field at zero holds the counter cleared and idle.
// [RULE7] Clock select 0, measurement: counter advances at half the bus clock.
// [RULE8] Clock select 0: start on receive falling edge, stop on the next.
// [RULE9] Clock select 0: running while counting; done sets on second falling edge.
// [RULE10] Clock select 1: half prescaler rate; start when receive is seen low.
// [RULE11] Clock select 1: receive already low at enable starts counting immediately.
// [RULE12] Clock select 1: stop at next receive rising edge, giving break length.
// [RULE13] Mode 10 is arbitration; every transmit rising edge restarts the counter. After a loss it stays stopped and ignores them until a control write.
// [RULE14] Arbitration senses receive at count 0x38 (select 0) or 0x08 (select 1).
// [RULE15] Receive sensed low sets the arbitration lost flag.
// [RULE16] While lost is set the transmit pin is forced high.
// [RULE17] Transmit low before any receive low resets counter and rearms arbitration.
// [RULE18] Mode 00 idle, 01 measure, 10 arbitrate, 11 reserved; reset clears.
// [RULE19] Lost flag read-only, cleared by writing 0 to mode high bit, or reset.
// [RULE20] Counter is nine bits with a separate overflow bit.
// [RULE21] With lost clear the transmit pin follows the internal transmit output.
//
// The implementer's own choices: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/100ps
module sab_bit_timer #(
  parameter int AW = 8
) (
  // Clock, reset, enable
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic ce,
  // Serial side
  input wire logic rxd_pin,
  input wire logic internal_transmit_output,
  input wire logic presc_tick,
  output logic txd_pin,
  // AXI4-Lite write
  input wire logic [AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  import sab_pkg::*;

  sab_mode_t mode_q;
  sab_state_t st_q, st_d;
  logic aclk_q, done_q, done_d, ovf_q, ovf_d, lost_q, lost_d, smp_q, smp_d;
  logic [8:0] cnt_q, cnt_d;
  logic rx_s1_q, rx_s2_q, rx_s3_q, rx_lvl_q, tx_prev_q, div_q, txd_q;
  logic bvalid_q, rvalid_q;
  logic [1:0] bresp_q, rresp_q;
  logic [31:0] rdata_q;

  // Receive pin: three stages, change taken once stages two and three agree
  wire rx_agree = (rx_s2_q == rx_s3_q);
  wire rx_fall = rx_lvl_q & rx_agree & ~rx_s2_q;
  wire rx_rise = ~rx_lvl_q & rx_agree & rx_s2_q;
  wire tx_rise = internal_transmit_output & ~tx_prev_q;
  wire tx_fall = ~internal_transmit_output & tx_prev_q;

  // Counter tick: halve either the bus clock or the prescaler pulse
  wire tick_src = aclk_q ? presc_tick : 1'b1; // [RULE7] [RULE10]
  wire tick = ce & tick_src & div_q;

  // Write path waits for address and data together, one response at a time
  wire wr_go = s_axi_awvalid & s_axi_wvalid & ~bvalid_q;
  wire wr_ctrl_hit = (s_axi_awaddr[AW-1:2] == SAB_OFF_CTRL[AW-1:2]);
  wire wr_cnt_hit = (s_axi_awaddr[AW-1:2] == SAB_OFF_CNT[AW-1:2]);
  wire wr_map = wr_ctrl_hit | wr_cnt_hit;
  wire ctrl_wr = ce & wr_go & wr_ctrl_hit & s_axi_wstrb[0];
  wire rd_go = s_axi_arvalid & ~rvalid_q;
  wire rd_ctrl_hit = (s_axi_araddr[AW-1:2] == SAB_OFF_CTRL[AW-1:2]);
  wire rd_cnt_hit = (s_axi_araddr[AW-1:2] == SAB_OFF_CNT[AW-1:2]);
  wire sab_mode_t wmode = sab_mode_t'({s_axi_wdata[SAB_MODE_HI_BIT], s_axi_wdata[SAB_MODE_LO_BIT]});

  wire sab_ctrl_t ctrl_view = '{
    mode_select_high: mode_q[1],
    mode_select_low: mode_q[0],
    arbitration_lost_flag: lost_q,
    clock_select: aclk_q,
    measure_done_flag: done_q,
    counter_running_flag: (st_q == SAB_ST_RUN), // [RULE2]
    counter_overflow_flag: ovf_q,
    counter_msb: cnt_q[SAB_CNT_W-1] // [RULE4]
  };
  wire [31:0] rd_word = rd_ctrl_hit ? {24'h000000, ctrl_view} :
    rd_cnt_hit ? {24'h000000, cnt_q[SAB_REG_W-1:0]} : SAB_WORD_ZERO; // [RULE5]

  wire arb_mode = (mode_q == SAB_MODE_ARB); // [RULE13] [RULE18]
  wire meas_mode = (mode_q == SAB_MODE_MEAS);
  wire [8:0] sense_pt = aclk_q ? SAB_SENSE_PRE : SAB_SENSE_BUS; // [RULE14]
  wire sense_now = arb_mode & (st_q == SAB_ST_RUN) & (cnt_q == sense_pt) & ~smp_q;
  wire lost_set = sense_now & ~rx_lvl_q; // [RULE15]

  assign s_axi_awready = wr_go;
  assign s_axi_wready = wr_go;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = rd_go;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rresp = rresp_q;
  assign s_axi_rdata = rdata_q;
  assign txd_pin = txd_q;

  // Sequencer and counter
  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q;
    done_d = done_q;
    ovf_d = ovf_q;
    smp_d = smp_q;
    lost_d = lost_q;
    if (ctrl_wr && !s_axi_wdata[SAB_MODE_HI_BIT]) begin
      lost_d = 1'b0; // [RULE19]
    end
    if (lost_set) begin
      lost_d = 1'b1; // [RULE15]
    end
    if (mode_q == SAB_MODE_IDLE || mode_q == SAB_MODE_RSVD) begin
      st_d = SAB_ST_IDLE; // [RULE6]
      cnt_d = SAB_CNT_ZERO;
    end else begin
      case (st_q)
        SAB_ST_IDLE: begin
          st_d = SAB_ST_ARM;
          cnt_d = SAB_CNT_ZERO;
        end
        SAB_ST_ARM: begin
          if (meas_mode && !aclk_q && rx_fall) begin
            st_d = SAB_ST_RUN; // [RULE8]
          end else if (meas_mode && aclk_q && !rx_lvl_q) begin
            st_d = SAB_ST_RUN; // [RULE10] [RULE11]
          end else if (arb_mode && tx_rise) begin
            st_d = SAB_ST_RUN; // [RULE13]
            smp_d = 1'b0;
          end
        end
        SAB_ST_RUN: begin
          if (tick) begin
            cnt_d = cnt_q + SAB_CNT_ONE;
            if (cnt_q == SAB_CNT_MAX) begin
              ovf_d = 1'b1; // [RULE3] [RULE20]
            end
          end
          if (sense_now) begin
            smp_d = 1'b1; // [RULE14]
          end
          if (meas_mode && !aclk_q && rx_fall) begin
            st_d = SAB_ST_STOP; // [RULE9]
            done_d = 1'b1;
          end else if (meas_mode && aclk_q && rx_rise) begin
            st_d = SAB_ST_STOP; // [RULE12]
            done_d = 1'b1;
          end else if (lost_set) begin
            st_d = SAB_ST_STOP;
          end else if (arb_mode && tx_fall) begin
            st_d = SAB_ST_ARM; // [RULE17]
            cnt_d = SAB_CNT_ZERO;
          end else if (arb_mode && tx_rise) begin
            cnt_d = SAB_CNT_ZERO; // [RULE13]
            smp_d = 1'b0;
          end
        end
        SAB_ST_STOP: begin
          st_d = SAB_ST_STOP;
        end
        default: begin
          st_d = SAB_ST_IDLE;
        end
      endcase
    end
    // A control write restarts the sequence; a same-cycle finish still lands
    if (ctrl_wr) begin
      st_d = SAB_ST_IDLE;
      cnt_d = SAB_CNT_ZERO; // [RULE4] [RULE5]
      ovf_d = 1'b0; // [RULE3]
      done_d = 1'b0; // [RULE1]
      smp_d = 1'b0;
      if (st_q == SAB_ST_RUN && meas_mode && ((!aclk_q && rx_fall) || (aclk_q && rx_rise))) begin
        done_d = 1'b1; // [RULE1]
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      rx_s1_q <= 1'b1;
      rx_s2_q <= 1'b1;
      rx_s3_q <= 1'b1;
      rx_lvl_q <= 1'b1;
      tx_prev_q <= 1'b1;
      div_q <= 1'b0;
    end else if (ce) begin
      rx_s1_q <= rxd_pin;
      rx_s2_q <= rx_s1_q;
      rx_s3_q <= rx_s2_q;
      if (rx_agree) begin
        rx_lvl_q <= rx_s2_q;
      end
      tx_prev_q <= internal_transmit_output;
      if (tick_src) begin
        div_q <= ~div_q; // [RULE7]
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      st_q <= SAB_ST_IDLE;
      cnt_q <= SAB_CNT_ZERO;
      done_q <= 1'b0;
      ovf_q <= 1'b0;
      lost_q <= 1'b0;
      smp_q <= 1'b0;
      txd_q <= 1'b1;
    end else if (ce) begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      done_q <= done_d;
      ovf_q <= ovf_d;
      lost_q <= lost_d;
      smp_q <= smp_d;
      txd_q <= lost_q | internal_transmit_output; // [RULE16] [RULE21]
    end
  end

  // Register writes and bus answers
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      mode_q <= SAB_MODE_IDLE; // [RULE18]
      aclk_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= SAB_RESP_OKAY;
    end else if (ce) begin
      if (ctrl_wr) begin
        mode_q <= wmode;
        aclk_q <= s_axi_wdata[SAB_ACLK_BIT];
      end
      if (wr_go) begin
        bvalid_q <= 1'b1;
        bresp_q <= wr_map ? SAB_RESP_OKAY : SAB_RESP_SLVERR;
      end else if (s_axi_bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      rvalid_q <= 1'b0;
      rresp_q <= SAB_RESP_OKAY;
      rdata_q <= SAB_WORD_ZERO;
    end else if (ce) begin
      if (rd_go) begin
        rvalid_q <= 1'b1;
        rdata_q <= rd_word;
        rresp_q <= (rd_ctrl_hit | rd_cnt_hit) ? SAB_RESP_OKAY : SAB_RESP_SLVERR;
      end else if (s_axi_rready) begin
        rvalid_q <= 1'b0;
      end
    end
  end

  // Checks
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!resetn);

  sequence meas_fall_s;
    ce && st_q == SAB_ST_RUN && meas_mode && !aclk_q && rx_fall && !ctrl_wr;
  endsequence
  sequence stopped_s;
    done_q && st_q == SAB_ST_STOP && !ctrl_view.counter_running_flag;
  endsequence

  txd_force_a: assert property (ce && lost_q |=> txd_pin) // [RULE16]
    else $error("transmit pin not forced high while lost");
  txd_pass_a: assert property (ce && !lost_q |=> txd_pin == $past(internal_transmit_output)) // [RULE21]
    else $error("transmit pin does not follow internal output");
  idle_clear_a: assert property (ce && mode_q == SAB_MODE_IDLE |=> cnt_q == SAB_CNT_ZERO && st_q == SAB_ST_IDLE) // [RULE6]
    else $error("counter not held clear in idle mode");
  half_rate_a: assert property (tick ##1 ce |-> !tick) // [RULE7]
    else $error("counter ticks on consecutive enabled cycles");
  count_step_a: assert property (tick && st_q == SAB_ST_RUN && st_d == SAB_ST_RUN && !ctrl_wr && !(arb_mode && tx_rise)
    |=> cnt_q == $past(cnt_q) + SAB_CNT_ONE) // [RULE7]
    else $error("counter did not advance on tick");
  ovf_set_a: assert property (tick && st_q == SAB_ST_RUN && cnt_q == SAB_CNT_MAX && !ctrl_wr |=> ovf_q) // [RULE3]
    else $error("overflow flag missed on wrap");
  wr_clear_a: assert property (ctrl_wr && st_q != SAB_ST_RUN |=> !done_q && !ovf_q && cnt_q == SAB_CNT_ZERO) // [RULE1]
    else $error("control write did not clear flags and counter");
  lost_set_a: assert property (ce && lost_set |=> lost_q ##1 (!ce || txd_pin)) // [RULE15]
    else $error("low sense did not set lost and seize transmit");
  lost_clr_a: assert property (ctrl_wr && !s_axi_wdata[SAB_MODE_HI_BIT] && !lost_set |=> !lost_q) // [RULE19]
    else $error("lost flag not cleared by mode high write of zero");
  meas_stop_a: assert property (meas_fall_s |=> stopped_s) // [RULE9]
    else $error("second falling edge did not stop and finish");
  arb_rearm_a: assert property (ce && arb_mode && st_q == SAB_ST_RUN && tx_fall && !lost_set && !ctrl_wr
    |=> st_q == SAB_ST_ARM && cnt_q == SAB_CNT_ZERO) // [RULE17]
    else $error("transmit low did not reset and rearm");

  // Sticky flags only fall on a control write
  done_hold_a: assert property (done_q && !ctrl_wr // [RULE1]
    |=> done_q)
    else $error("done flag dropped without a control write");
  ovf_hold_a: assert property (ovf_q && !ctrl_wr // [RULE3]
    |=> ovf_q)
    else $error("overflow flag dropped without a control write");
  lost_hold_a: assert property (lost_q && !ctrl_wr // [RULE19]
    |=> lost_q)
    else $error("lost flag dropped without a control write");

  // A stopped counter keeps its result for software
  stop_freeze_a: assert property (ce && st_q == SAB_ST_STOP && !ctrl_wr // [RULE2]
    |=> cnt_q == $past(cnt_q) && !ctrl_view.counter_running_flag)
    else $error("stopped counter moved or reads running");
  rsvd_idle_a: assert property (ce && mode_q == SAB_MODE_RSVD // [RULE18]
    |=> cnt_q == SAB_CNT_ZERO)
    else $error("reserved mode did not hold the counter clear");
  wrap_zero_a: assert property (tick && st_q == SAB_ST_RUN && st_d == SAB_ST_RUN && cnt_q == SAB_CNT_MAX && !ctrl_wr // [RULE20]
    |=> cnt_q == SAB_CNT_ZERO)
    else $error("counter did not wrap to zero");

  // Read views of the counter
  msb_view_a: assert property (ce && rd_go && rd_ctrl_hit // [RULE4]
    |=> s_axi_rdata[0] == $past(cnt_q[SAB_CNT_W-1]))
    else $error("control read lost the counter top bit");
  low_view_a: assert property (ce && rd_go && rd_cnt_hit // [RULE5]
    |=> s_axi_rdata[SAB_REG_W-1:0] == $past(cnt_q[SAB_REG_W-1:0]) && s_axi_rdata[31:SAB_REG_W] == 24'h000000)
    else $error("data read lost the counter low bits");

  // Start and stop conditions
  sequence arm_ok_s;
    ce && st_q == SAB_ST_ARM && !ctrl_wr;
  endsequence
  arm_still_a: assert property (arm_ok_s // [RULE8]
    |=> cnt_q == SAB_CNT_ZERO)
    else $error("counter moved while armed");
  meas_start_a: assert property (arm_ok_s and (meas_mode && !aclk_q && rx_fall) // [RULE8]
    |=> st_q == SAB_ST_RUN)
    else $error("falling edge did not start the count");
  brk_start_a: assert property (arm_ok_s and (meas_mode && aclk_q && !rx_lvl_q) // [RULE11]
    |=> st_q == SAB_ST_RUN)
    else $error("low receive level did not start the count");
  brk_stop_a: assert property (ce && st_q == SAB_ST_RUN && meas_mode && aclk_q && rx_rise && !ctrl_wr // [RULE12]
    |=> done_q && st_q == SAB_ST_STOP)
    else $error("rising edge did not end the break count");
  arb_start_a: assert property (arm_ok_s and (arb_mode && tx_rise) // [RULE13]
    |=> st_q == SAB_ST_RUN && cnt_q == SAB_CNT_ZERO)
    else $error("transmit rising edge did not start arbitration");
  arb_restart_a: assert property (ce && st_q == SAB_ST_RUN && arb_mode && tx_rise && !lost_set && !ctrl_wr // [RULE13]
    |=> cnt_q == SAB_CNT_ZERO)
    else $error("transmit rising edge did not restart the counter");
  sense_once_a: assert property (ce && sense_now && !ctrl_wr // [RULE14]
    |=> smp_q)
    else $error("sense point not recorded");
  lost_stop_a: assert property (ce && lost_set && !ctrl_wr // [RULE15]
    |=> st_q == SAB_ST_STOP)
    else $error("lost arbitration did not stop the counter");

  // Bus answers stand until taken
  b_stand_a: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid)
    else $error("write response withdrawn before it was taken");
  r_stand_a: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer changed before it was taken");
endmodule

// *** sim/sab_bus_node.sv ***
// Other node on the shared single-wire serial bus
`timescale 1ns/100ps
module sab_bus_node (
  // Our pin and the other node's drive
  input wire logic txd_pin,
  input wire logic node_tx,
  // Level seen on the wire
  output logic bus
);
  // Open-drain with pull-up: a low from either party wins
  assign bus = txd_pin & node_tx;
endmodule

// *** sim/testbench.sv ***
// Self-checking bench for the serial arbiter bit timer
`timescale 1ns/100ps
module testbench;
  import sab_pkg::*;
  logic ref_clk = 1'b0;
  logic resetn = 1'b0;
  logic itx = 1'b1;
  logic node_tx = 1'b1;
  logic presc_tick = 1'b0;
  logic awv = 1'b0;
  logic wv = 1'b0;
  logic bready = 1'b0;
  logic arv = 1'b0;
  logic rready = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h00000000;
  logic [31:0] rdata, rd;
  logic [1:0] bresp, rresp, rs;
  logic awready, wready, bvalid, arready, rvalid, txd_pin, rxd_pin;
  logic [1:0] pc = 2'h0;
  logic [8:0] v;
  int cycles = 0;
  int miscompares = 0;
  int check_count = 0;
  always #2.5 ref_clk = ~ref_clk;
  // Prescaler pulse every fourth cycle
  always @(posedge ref_clk) begin
    pc <= pc + 2'h1;
    presc_tick <= (pc == 2'h3);
    cycles <= cycles + 1;
  end
  sab_bus_node node (.txd_pin(txd_pin), .node_tx(node_tx), .bus(rxd_pin));
  sab_bit_timer DUT (.ref_clk(ref_clk), .resetn(resetn), .ce(1'b1), .rxd_pin(rxd_pin),
    .internal_transmit_output(itx), .presc_tick(presc_tick), .txd_pin(txd_pin),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awv), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wv), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arv),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready));
  task automatic conclude();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Edge phase of the synchroniser leaves one count of slack
  task automatic chk_near(string what, logic [8:0] exp, logic [8:0] got);
    check_count++;
    if ((got + 9'h001 >= exp && got <= exp + 9'h001) !== 1'b1) begin
      miscompares++;
      $display("unexpected %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic guard(int n);
    if (n >= 100) begin
      miscompares++;
      $display("unexpected handshake expected 1 seen 0");
      conclude();
    end
  endtask
  task automatic cyc(int n);
    repeat (n) @(posedge ref_clk);
  endtask
  task automatic axw(logic [7:0] a, logic [31:0] d);
    int n;
    n = 0;
    awaddr <= a;
    wdata <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    do begin
      @(posedge ref_clk);
      n++;
    end while (awready !== 1'b1 && n < 100);
    guard(n);
    awv <= 1'b0;
    wv <= 1'b0;
    bready <= 1'b1;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (bvalid !== 1'b1 && n < 100);
    guard(n);
    rs = bresp;
    bready <= 1'b0;
  endtask
  task automatic axr(logic [7:0] a);
    int n;
    n = 0;
    araddr <= a;
    arv <= 1'b1;
    do begin
      @(posedge ref_clk);
      n++;
    end while (arready !== 1'b1 && n < 100);
    guard(n);
    arv <= 1'b0;
    rready <= 1'b1;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (rvalid !== 1'b1 && n < 100);
    guard(n);
    rd = rdata;
    rs = rresp;
    rready <= 1'b0;
  endtask
  task automatic rc(logic [7:0] a, logic [31:0] exp);
    axr(a);
    chk("register", exp, rd);
  endtask
  task automatic rdcount(logic [8:0] exp);
    axr(SAB_OFF_CTRL);
    v[8] = rd[0];
    axr(SAB_OFF_CNT);
    v[7:0] = rd[7:0];
    chk_near("count", exp, v);
  endtask
  // Two falling edges len cycles apart, control read halfway
  task automatic meas(int len, logic [31:0] mid);
    int t0;
    t0 = cycles;
    node_tx <= 1'b0;
    cyc(4);
    node_tx <= 1'b1;
    cyc(len / 2);
    rc(SAB_OFF_CTRL, mid);
    while (cycles < t0 + len) @(posedge ref_clk);
    node_tx <= 1'b0;
    cyc(4);
    node_tx <= 1'b1;
    cyc(10);
  endtask
  // One transmit bit: low phase, rising edge, optional dominant window
  task automatic arb(int tl, int nl, logic txd_exp);
    itx <= 1'b0;
    cyc(tl);
    chk("txd_pin", {31'h0, txd_exp}, {31'h0, txd_pin});
    itx <= 1'b1;
    cyc(5);
    if (nl > 0) begin
      node_tx <= 1'b0;
      cyc(nl);
      node_tx <= 1'b1;
    end
    cyc(20);
  endtask
  initial begin
    cyc(12);
    resetn <= 1'b1;
    cyc(1);
    rc(SAB_OFF_CTRL, 32'h00000000);
    rc(SAB_OFF_CNT, 32'h00000000);
    rc(8'h08, 32'h00000000);
    chk("rresp", {30'h0, SAB_RESP_SLVERR}, {30'h0, rs});
    $display("test reset done");
    axw(SAB_OFF_CTRL, 32'h00000040);
    meas(600, 32'h00000044);
    rc(SAB_OFF_CTRL, 32'h00000049);
    rdcount(9'h12C);
    axw(SAB_OFF_CNT, 32'h000000FF);
    chk("bresp", {30'h0, SAB_RESP_OKAY}, {30'h0, rs});
    rc(SAB_OFF_CNT, 32'h0000002C);
    axw(SAB_OFF_CTRL, 32'h00000040);
    rc(SAB_OFF_CTRL, 32'h00000040);
    rc(SAB_OFF_CNT, 32'h00000000);
    $display("test bit time done");
    meas(1100, 32'h00000045);
    rc(SAB_OFF_CTRL, 32'h0000004A);
    rdcount(9'h026);
    axw(SAB_OFF_CTRL, 32'h00000040);
    rc(SAB_OFF_CTRL, 32'h00000040);
    $display("test overflow done");
    for (int i = 0; i < 2; i++) begin
      axw(SAB_OFF_CTRL, i == 0 ? 32'h00000000 : 32'h000000C0);
      meas(200, i == 0 ? 32'h00000000 : 32'h000000C0);
      rc(SAB_OFF_CNT, 32'h00000000);
    end
    $display("test idle modes done");
    node_tx <= 1'b0;
    cyc(10);
    axw(SAB_OFF_CTRL, 32'h00000050);
    v = 9'h000;
    cyc(100);
    rc(SAB_OFF_CTRL, 32'h00000054);
    cyc(290);
    node_tx <= 1'b1;
    cyc(20);
    rc(SAB_OFF_CTRL, 32'h00000058);
    rdcount(9'h032);
    $display("test break done");
    axw(SAB_OFF_CTRL, 32'h00000080);
    arb(20, 85, 1'b0);
    rc(SAB_OFF_CTRL, 32'h00000084);
    arb(20, 60, 1'b0);
    arb(40, 0, 1'b0);
    rc(SAB_OFF_CTRL, 32'h00000084);
    arb(20, 145, 1'b0);
    rc(SAB_OFF_CTRL, 32'h000000A0);
    arb(20, 0, 1'b1);
    axw(SAB_OFF_CTRL, 32'h00000000);
    rc(SAB_OFF_CTRL, 32'h00000000);
    axw(SAB_OFF_CTRL, 32'h00000090);
    arb(20, 30, 1'b0);
    rc(SAB_OFF_CTRL, 32'h00000094);
    arb(20, 110, 1'b0);
    rc(SAB_OFF_CTRL, 32'h000000B0);
    $display("test arbitration done");
    conclude();
  end
endmodule
